// file: cct_timer.sv
// capture compare timer with wishbone register slave
// Summary of operation
// - one prescaled 16-bit counter and eight 16-bit capture or compare channels
// - role bit 0 selects capture, 1 selects compare
// - force bits run the compare action now, flag untouched; force reads zero
// - masked channel in compare role drives its pin regardless of direction bit
// - master compare copies master data into each masked port bit whose channel is in compare role
// - master compare beats other channel compare on masked bits same cycle
// - counter writes only work in special mode; first period may differ
// - enable low stops counter and removes divide-by-64 clock
// - stop-in-wait halts timer during wait mode
// - stop-in-background halts timer in debug mode, else runs
// - fast clear: capture value read or compare value write clears flag
// - fast clear: counter access clears overflow; accumulator access clears its flags
// - nonzero action pair makes pin an output of that compare channel
// - action codes: disconnect, toggle, drive low, drive high
// - edge codes: off, rising, falling, either
// - channel enable gates its flag onto interrupt request
// - overflow enable gates overflow flag onto interrupt request
// - counter reset enable makes master compare zero the counter
// - master value zero holds counter at zero; all ones never overflows
// - active compare on a pin overrides its direction bit
// - port data writes to a timer-held pin only update the latch
// - prescale codes divide by 1 to 32; new code waits for stages zero
// - overflow flag sets when counter wraps from all ones to zero
// - writing one clears a flag, zero leaves it
// - capture latches the counter on its edge; compare fires on equality
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module cct_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mcu mode
  input wire logic mcu_wait,
  input wire logic mcu_background,
  // timer port pins
  input wire logic [7:0] pin_in,
  output cct_pkg::cct_pins_s pins,
  // interrupt requests and accumulator clock
  output logic [7:0] ch_irq,
  output logic ovf_irq,
  output logic pa_clk_tick
);
  cct_pkg::cct_state_s s, n;
  logic [7:0] pin_s1, pin_s2;

  function automatic logic [1:0] pair(input logic [15:0] v, input int i);
    pair = v[2*i +: 2];
  endfunction : pair

  function automatic logic [4:0] pre_mask(input logic [2:0] code);
    pre_mask = 5'((6'h01 << code) - 6'h01);
  endfunction : pre_mask

  // pin synchroniser
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= cct_pkg::RST_BYTE;
      pin_s2 <= cct_pkg::RST_BYTE;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  logic running, tick, wr, rd, acc, m7_match, ovf_set;
  logic [7:0] match, cap_ev, force_v, fire, timer_own, m7_own;
  logic [15:0] wword;

  always_comb begin
    n = s;
    acc = wb_cyc_i && wb_stb_i && !s.ack;
    wr = acc && wb_we_i;
    rd = acc && !wb_we_i;
    wword = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    running = s.sysctl[cct_pkg::SYS_EN_BIT]
      && !(s.sysctl[cct_pkg::SYS_WAIT_BIT] && mcu_wait)
      && !(s.sysctl[cct_pkg::SYS_BDM_BIT] && mcu_background);
    // prescaler, new code only when all stages zero
    tick = 1'b0;
    if (running) begin
      n.pre_cnt = (s.pre_cnt + 5'h01) & pre_mask(s.pre_active);
      tick = ((s.pre_cnt & pre_mask(s.pre_active)) == pre_mask(s.pre_active));
      if (n.pre_cnt == 5'h00) begin
        n.pre_active = (s.ovf_ctl[2:0] > cct_pkg::PRE_MAX_CODE) ? s.pre_active
                                                                : s.ovf_ctl[2:0];
      end
      n.div64_cnt = s.div64_cnt + 6'h01;
    end
    pa_clk_tick = running && (s.div64_cnt == cct_pkg::DIV64_LAST);
    // compares and captures
    force_v = (wr && wb_adr_i == cct_pkg::OFF_FORCE && wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
    for (int i = 0; i < 8; i++) begin
      // one match per prescaled period, so a toggle action fires once
      match[i] = s.role[i] && tick && (s.count == s.value[16*i +: 16]);
      cap_ev[i] = !s.role[i] && ((s.edges[2*i] && !s.pin_prev[i] && pin_s2[i])
        || (s.edges[2*i+1] && s.pin_prev[i] && !pin_s2[i]));
      if (cap_ev[i]) n.value[16*i +: 16] = s.count;
    end
    n.pin_prev = pin_s2;
    fire = (match | force_v) & s.role;
    m7_match = fire[7];
    // output actions
    for (int i = 0; i < 8; i++) begin
      if (fire[i]) begin
        case (pair(s.act, i))
          2'b01: n.oc_level[i] = !s.oc_level[i];
          2'b10: n.oc_level[i] = 1'b0;
          2'b11: n.oc_level[i] = 1'b1;
          default: n.oc_level[i] = s.oc_level[i];
        endcase
      end
      if (m7_match && s.m7mask[i]) n.oc_level[i] = s.m7data[i];
    end
    // counter
    ovf_set = tick && s.count == cct_pkg::COUNT_MAX
      && !(match[7] && s.ovf_ctl[cct_pkg::OVF_CRE_BIT]);
    if (tick) begin
      if (match[7] && s.ovf_ctl[cct_pkg::OVF_CRE_BIT]) begin
        n.count = cct_pkg::RST_WORD;
      end else begin
        n.count = s.count + 16'h0001;
      end
    end
    // software clears first, hardware sets win
    if (wr && wb_adr_i == cct_pkg::OFF_CH_FLAGS && wb_sel_i[0]) begin
      n.ch_flags = s.ch_flags & ~wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == cct_pkg::OFF_OVF_FLAGS && wb_sel_i[0]
        && wb_dat_i[cct_pkg::OVF_FLAG_BIT]) begin
      n.ovf_flag = 1'b0;
    end
    if (s.sysctl[cct_pkg::SYS_FFC_BIT]) begin
      for (int i = 0; i < 8; i++) begin
        if (wb_adr_i[7:1] == 7'(({1'b0, cct_pkg::OFF_CH_VALUE0} + 9'(2*i)) >> 1)) begin
          if ((rd && !s.role[i]) || (wr && s.role[i])) n.ch_flags[i] = 1'b0;
        end
      end
      if (acc && wb_adr_i[7:1] == cct_pkg::OFF_COUNT[7:1]) begin
        n.ovf_flag = 1'b0;
      end
      if (acc && wb_adr_i[7:1] == cct_pkg::OFF_PA_COUNT[7:1]) n.pa_flags = 2'b00;
    end
    n.ch_flags = n.ch_flags | (match & s.role) | cap_ev;
    n.ovf_flag = n.ovf_flag || ovf_set;
    // register writes
    if (wr) begin
      case (wb_adr_i)
        cct_pkg::OFF_ROLE: if (wb_sel_i[0]) n.role = wb_dat_i[7:0];
        cct_pkg::OFF_M7MASK: if (wb_sel_i[0]) n.m7mask = wb_dat_i[7:0];
        cct_pkg::OFF_M7DATA: if (wb_sel_i[0]) n.m7data = wb_dat_i[7:0];
        cct_pkg::OFF_COUNT: if (s.special) begin
          n.count = wword;
        end
        cct_pkg::OFF_SYSCTL: if (wb_sel_i[0]) n.sysctl = wb_dat_i[7:0] & 8'hf0;
        cct_pkg::OFF_ACT_HI: if (wb_sel_i[0]) n.act[15:8] = wb_dat_i[7:0];
        cct_pkg::OFF_ACT_LO: if (wb_sel_i[0]) n.act[7:0] = wb_dat_i[7:0];
        cct_pkg::OFF_EDGE_HI: if (wb_sel_i[0]) n.edges[15:8] = wb_dat_i[7:0];
        cct_pkg::OFF_EDGE_LO: if (wb_sel_i[0]) n.edges[7:0] = wb_dat_i[7:0];
        cct_pkg::OFF_CH_IE: if (wb_sel_i[0]) n.ch_ie = wb_dat_i[7:0];
        cct_pkg::OFF_OVF_CTL: if (wb_sel_i[0]) n.ovf_ctl = wb_dat_i[7:0];
        cct_pkg::OFF_PORT_DATA: if (wb_sel_i[0]) n.port_data = wb_dat_i[7:0];
        cct_pkg::OFF_PORT_DIR: if (wb_sel_i[0]) n.port_dir = wb_dat_i[7:0];
        cct_pkg::OFF_SPECIAL: if (wb_sel_i[0]) n.special = wb_dat_i[0];
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (s.role[i] && wb_adr_i == 8'(cct_pkg::OFF_CH_VALUE0 + 8'(2*i))) begin
              n.value[16*i +: 16] = wword;
            end
          end
        end
      endcase
    end
    // read mux
    n.rdata = 32'h0000_0000;
    if (rd) begin
      case (wb_adr_i)
        cct_pkg::OFF_ROLE: n.rdata[7:0] = s.role;
        cct_pkg::OFF_FORCE: n.rdata[7:0] = 8'h00;
        cct_pkg::OFF_M7MASK: n.rdata[7:0] = s.m7mask;
        cct_pkg::OFF_M7DATA: n.rdata[7:0] = s.m7data;
        cct_pkg::OFF_COUNT: n.rdata[15:0] = s.count;
        cct_pkg::OFF_SYSCTL: n.rdata[7:0] = s.sysctl;
        cct_pkg::OFF_ACT_HI: n.rdata[7:0] = s.act[15:8];
        cct_pkg::OFF_ACT_LO: n.rdata[7:0] = s.act[7:0];
        cct_pkg::OFF_EDGE_HI: n.rdata[7:0] = s.edges[15:8];
        cct_pkg::OFF_EDGE_LO: n.rdata[7:0] = s.edges[7:0];
        cct_pkg::OFF_CH_IE: n.rdata[7:0] = s.ch_ie;
        cct_pkg::OFF_OVF_CTL: n.rdata[7:0] = s.ovf_ctl;
        cct_pkg::OFF_CH_FLAGS: n.rdata[7:0] = s.ch_flags;
        cct_pkg::OFF_OVF_FLAGS: n.rdata[cct_pkg::OVF_FLAG_BIT] = s.ovf_flag;
        cct_pkg::OFF_PORT_DATA: n.rdata[7:0] = s.port_data;
        cct_pkg::OFF_PORT_DIR: n.rdata[7:0] = s.port_dir;
        cct_pkg::OFF_SPECIAL: n.rdata[0] = s.special;
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (wb_adr_i == 8'(cct_pkg::OFF_CH_VALUE0 + 8'(2*i))) begin
              n.rdata[15:0] = s.value[16*i +: 16];
            end
          end
        end
      endcase
    end
    n.ack = acc;
    // pin ownership
    for (int i = 0; i < 8; i++) begin
      m7_own[i] = s.role[i] && s.m7mask[i];
      timer_own[i] = (s.role[i] && pair(s.act, i) != 2'b00) || m7_own[i];
    end
    pins.pin_out = (timer_own & s.oc_level) | (~timer_own & s.port_data);
    pins.pin_oe = timer_own | s.port_dir;
    ch_irq = s.ch_flags & s.ch_ie;
    ovf_irq = s.ovf_flag && s.ovf_ctl[cct_pkg::OVF_IE_BIT];
    wb_ack_o = s.ack;
    wb_dat_o = s.rdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : cct_timer

// file: cct_pkg.sv
// package for the capture compare timer: register map, fields, carriers
package cct_pkg;
  // register byte offsets (one byte each, 16-bit registers take two)
  localparam logic [7:0] OFF_ROLE = 8'h80;
  localparam logic [7:0] OFF_FORCE = 8'h81;
  localparam logic [7:0] OFF_M7MASK = 8'h82;
  localparam logic [7:0] OFF_M7DATA = 8'h83;
  localparam logic [7:0] OFF_COUNT = 8'h84;
  localparam logic [7:0] OFF_SYSCTL = 8'h86;
  localparam logic [7:0] OFF_ACT_HI = 8'h88;
  localparam logic [7:0] OFF_ACT_LO = 8'h89;
  localparam logic [7:0] OFF_EDGE_HI = 8'h8a;
  localparam logic [7:0] OFF_EDGE_LO = 8'h8b;
  localparam logic [7:0] OFF_CH_IE = 8'h8c;
  localparam logic [7:0] OFF_OVF_CTL = 8'h8d;
  localparam logic [7:0] OFF_CH_FLAGS = 8'h8e;
  localparam logic [7:0] OFF_OVF_FLAGS = 8'h8f;
  localparam logic [7:0] OFF_CH_VALUE0 = 8'h90;
  localparam logic [7:0] OFF_PA_COUNT = 8'ha2;
  localparam logic [7:0] OFF_PORT_DATA = 8'ha4;
  localparam logic [7:0] OFF_PORT_DIR = 8'ha5;
  localparam logic [7:0] OFF_SPECIAL = 8'ha6;
  // field positions
  localparam int SYS_EN_BIT = 7;
  localparam int SYS_WAIT_BIT = 6;
  localparam int SYS_BDM_BIT = 5;
  localparam int SYS_FFC_BIT = 4;
  localparam int OVF_IE_BIT = 7;
  localparam int OVF_CRE_BIT = 3;
  localparam int OVF_FLAG_BIT = 7;
  localparam int PA_OVF_BIT = 1;
  localparam int PA_IN_BIT = 0;
  // reset values and limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  localparam logic [2:0] PRE_MAX_CODE = 3'h5;

  typedef struct packed {
    logic [7:0] role;
    logic [7:0] m7mask;
    logic [7:0] m7data;
    logic [7:0] sysctl;
    logic [15:0] act;
    logic [15:0] edges;
    logic [7:0] ch_ie;
    logic [7:0] ovf_ctl;
    logic [2:0] pre_active;
    logic [7:0] ch_flags;
    logic ovf_flag;
    logic [1:0] pa_flags;
    logic [15:0] count;
    logic [4:0] pre_cnt;
    logic [5:0] div64_cnt;
    logic [127:0] value;
    logic [7:0] oc_level;
    logic [7:0] port_data;
    logic [7:0] port_dir;
    logic [7:0] pin_prev;
    logic [31:0] rdata;
    logic ack;
    logic special;
  } cct_state_s;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } cct_pins_s;
endpackage : cct_pkg

// file: cct_timer_monitor.sv
// port checker for the capture compare timer, bound to its top
`timescale 1ns/1ps
module cct_timer_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // modes, pins and requests
  input wire logic mcu_wait,
  input wire logic mcu_background,
  input wire logic [7:0] pin_in,
  input wire cct_pkg::cct_pins_s pins,
  input wire logic [7:0] ch_irq,
  input wire logic ovf_irq,
  input wire logic pa_clk_tick
);
  logic rd;
  logic wr;
  assign rd = wb_ack_o && !wb_we_i;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack late");
  property p_force_zero;
    rd && wb_adr_i == cct_pkg::OFF_FORCE |-> wb_dat_o == 32'h0;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force read nonzero");
  property p_odd_zero; rd && wb_adr_i == 8'h85 |-> wb_dat_o == 32'h0; endproperty
  a_odd_zero: assert property (p_odd_zero) else $error("odd half nonzero");
  property p_ie_off;
    wr && wb_adr_i == cct_pkg::OFF_CH_IE && wb_dat_i[7:0] == 8'h00 |=> ch_irq == 8'h00;
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("channel request not gated");
  property p_ovf_off;
    wr && wb_adr_i == cct_pkg::OFF_OVF_CTL && !wb_dat_i[7] |=> !ovf_irq;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("overflow request not gated");
  property p_stop_tick;
    wr && wb_adr_i == cct_pkg::OFF_SYSCTL && !wb_dat_i[7] |=> !pa_clk_tick [*8];
  endproperty
  a_stop_tick: assert property (p_stop_tick) else $error("tick while disabled");
  property p_tick_gap; pa_clk_tick |=> !pa_clk_tick [*8]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
endmodule : cct_timer_monitor

bind cct_timer cct_timer_monitor cct_timer_monitor_inst (
  .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .mcu_wait, .mcu_background, .pin_in, .pins, .ch_irq, .ovf_irq,
  .pa_clk_tick
);

// file: cct_pin_model.sv
// outside world on the timer port pins
`timescale 1ns/1ps
module cct_pin_model (
  // level the outside drives
  input wire logic [7:0] ext_level,
  // timer side
  input wire cct_pkg::cct_pins_s pins,
  output logic [7:0] pin_in
);
  // a driven pin reads back the timer's own level
  assign pin_in = (pins.pin_oe & pins.pin_out) | (~pins.pin_oe & ext_level);
endmodule : cct_pin_model

// file: test_cct_timer.sv
// self-checking bench for the capture compare timer
`timescale 1ns/1ps
module test_cct_timer;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic mcu_wait = 1'b0;
  logic mcu_background = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] pin_in;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] ch_irq;
  logic ovf_irq;
  cct_pkg::cct_pins_s pins;
  int errors = 0;
  int n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  cct_timer cct_timer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mcu_wait(mcu_wait), .mcu_background(mcu_background), .pin_in(pin_in), .pins(pins),
    .ch_irq(ch_irq), .ovf_irq(ovf_irq), .pa_clk_tick()
  );
  cct_pin_model cct_pin_model_inst (.ext_level(ext), .pins(pins), .pin_in(pin_in));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    chk("ack", 1'b1, wb_ack_o);
    q = wb_dat_o;
    cyc <= 1'b0;
    @(negedge clk_sys);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask : rd
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    while (ch_irq[b] !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk("request", 1'b1, ch_irq[b]);
  endtask : wait_irq
  task automatic t_reset;
    logic [7:0] al [6];
    logic [31:0] q;
    al = '{cct_pkg::OFF_ROLE, cct_pkg::OFF_FORCE, cct_pkg::OFF_SYSCTL, cct_pkg::OFF_CH_FLAGS,
           8'h00, 8'h85};
    foreach (al[i]) begin
      rd(al[i], q);
      chk("reset read", 32'h0, q);
    end
    $display("test reset reads done");
  endtask : t_reset
  task automatic t_compare;
    logic lv;
    logic e;
    wr(cct_pkg::OFF_ROLE, 16'h0083);
    wr(cct_pkg::OFF_M7MASK, 16'h0002);
    wr(cct_pkg::OFF_M7DATA, 16'h0002);
    wr(cct_pkg::OFF_CH_VALUE0 + 8'h0e, 16'h0040);
    wr(cct_pkg::OFF_OVF_CTL, 16'h0008);
    wr(cct_pkg::OFF_CH_IE, 16'h0005);
    wr(cct_pkg::OFF_SYSCTL, 16'h0090);
    chk("mask drive", 1'b1, pins.pin_oe[1]);
    for (int c = 1; c < 4; c++) begin
      wr(cct_pkg::OFF_ACT_LO, c[15:0]);
      wr(cct_pkg::OFF_CH_VALUE0, 16'h0010);
      lv = pins.pin_out[0];
      chk("fast clear", 1'b0, ch_irq[0]);
      wait_irq(0);
      e = (c == 1) ? ~lv : (c == 3);
      chk("action", e, pins.pin_out[0]);
      chk("action drive", 1'b1, pins.pin_oe[0]);
    end
    chk("master data", 1'b1, pins.pin_out[1]);
    wr(cct_pkg::OFF_CH_FLAGS, 16'h0000);
    chk("flag kept", 1'b1, ch_irq[0]);
    wr(cct_pkg::OFF_CH_FLAGS, 16'h0001);
    chk("flag cleared", 1'b0, ch_irq[0]);
    $display("test compare done");
  endtask : t_compare
  task automatic t_force;
    logic [31:0] a;
    logic [31:0] b;
    wr(cct_pkg::OFF_SYSCTL, 16'h0000);
    wr(cct_pkg::OFF_CH_FLAGS, 16'h00ff);
    wr(cct_pkg::OFF_ACT_LO, 16'h0002);
    wr(cct_pkg::OFF_FORCE, 16'h0001);
    chk("forced level", 1'b0, pins.pin_out[0]);
    chk("forced flag", 1'b0, ch_irq[0]);
    rd(cct_pkg::OFF_COUNT, a);
    repeat (70) @(negedge clk_sys);
    wr(cct_pkg::OFF_COUNT, 16'h1234);
    rd(cct_pkg::OFF_COUNT, b);
    chk("count held", a, b);
    wr(cct_pkg::OFF_CH_IE, 16'h0000);
    $display("test force done");
  endtask : t_force
  task automatic t_modes;
    logic [31:0] a;
    logic [31:0] b;
    @(posedge clk_sys);
    mcu_wait <= 1'b1;
    wr(cct_pkg::OFF_SYSCTL, 16'h00c0);
    rd(cct_pkg::OFF_COUNT, a);
    repeat (10) @(negedge clk_sys);
    rd(cct_pkg::OFF_COUNT, b);
    chk("wait halt", a, b);
    @(posedge clk_sys);
    mcu_wait <= 1'b0;
    mcu_background <= 1'b1;
    rd(cct_pkg::OFF_COUNT, a);
    repeat (10) @(negedge clk_sys);
    rd(cct_pkg::OFF_COUNT, b);
    chk("debug runs", 1'b1, a != b);
    $display("test modes done");
  endtask : t_modes
  task automatic t_capture;
    wr(cct_pkg::OFF_CH_IE, 16'h0004);
    for (int e = 1; e < 4; e++) begin
      wr(cct_pkg::OFF_EDGE_LO, {10'h000, e[1:0], 4'h0});
      wr(cct_pkg::OFF_CH_FLAGS, 16'h00ff);
      @(posedge clk_sys);
      ext[2] <= 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("rise capture", e != 2, ch_irq[2]);
      wr(cct_pkg::OFF_CH_FLAGS, 16'h00ff);
      @(posedge clk_sys);
      ext[2] <= 1'b0;
      repeat (6) @(negedge clk_sys);
      chk("fall capture", e != 1, ch_irq[2]);
    end
    $display("test capture done");
  endtask : t_capture
  task automatic t_overflow;
    logic [31:0] q;
    wr(cct_pkg::OFF_OVF_CTL, 16'h0080);
    wr(cct_pkg::OFF_SPECIAL, 16'h0001);
    wr(cct_pkg::OFF_COUNT, 16'hfff0);
    chk("no overflow yet", 1'b0, ovf_irq);
    repeat (20) @(negedge clk_sys);
    chk("overflow", 1'b1, ovf_irq);
    wr(cct_pkg::OFF_OVF_FLAGS, 16'h0080);
    chk("overflow cleared", 1'b0, ovf_irq);
    wr(cct_pkg::OFF_COUNT, 16'hfff0);
    repeat (20) @(negedge clk_sys);
    chk("overflow again", 1'b1, ovf_irq);
    wr(cct_pkg::OFF_SYSCTL, 16'h0090);
    rd(cct_pkg::OFF_COUNT, q);
    chk("fast overflow clear", 1'b0, ovf_irq);
    wr(cct_pkg::OFF_OVF_CTL, 16'h0002);
    wr(cct_pkg::OFF_COUNT, 16'h0000);
    repeat (40) @(negedge clk_sys);
    rd(cct_pkg::OFF_COUNT, q);
    chk("prescaled count", 1'b1, q >= 32'h0000_000a && q <= 32'h0000_000c);
    $display("test overflow done");
  endtask : t_overflow
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_compare();
    t_force();
    t_modes();
    t_capture();
    t_overflow();
    complete_run();
  end
endmodule : test_cct_timer
